// ==== cmd_defines.svh ====
/*
  Constants for the bus command front end: buffer size, command and marker characters,
  learn image lengths and header bytes.
  Assumes inclusion by bare name from the front end design file; the package does not include it.
*/
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH

`define STR_MAX          7'd82
`define CH_LF            8'h0A
`define CH_BANG          8'h21
`define CH_AT            8'h40
`define CH_TICK          8'hC0
`define CH_TWO           8'h32
`define CH_THREE         8'h33
`define CH_L             8'h4C
`define CH_ONE           8'h31
`define SHORT_LEN        8'd16
`define FULL_LEN         8'd189
`define SHORT_HDR0       8'h40
// Kept apart from the mode codes, so that a returned short image is never taken for @2.
`define SHORT_HDR1       8'h82
`define FULL_HDR0        8'hC0
`define FULL_HDR1        8'h31
`define SLOT_LEARN       4'h1

`endif

// ==== cmd_pkg.sv ====
/*
  Types shared by the command front end.
  Assumes cmd_defines.svh is on the include path.
*/
package cmd_pkg;
  typedef enum logic [1:0] {
    XF_NONE,
    XF_SHORT,
    XF_FULL
  } learn_kind_t;
  typedef logic [7:0] byte_t;
endpackage : cmd_pkg

// ==== sync2.sv ====
/*
  Two-flop synchroniser for a bank of pin levels.
  Assumes the pins are asynchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q   <= '0;
      pin_sync <= '0;
    end else begin
      meta_q   <= meta_d;
      pin_sync <= sync_d;
    end
  end
endmodule : sync2
`default_nettype wire

// ==== cmd_front.sv ====
/*
  Bus command front end: execution modes, string buffer, two-character command codes and
  the two learn image transfers with their panel side effects.
  Assumes a byte-level bus handshake outside: a listened byte is presented on rx_data with
  rx_valid and taken when rx_ready is high; talk bytes leave on tx_data/tx_valid/tx_eoi and
  are taken on tx_take. Bus lines ATN, EOI and the local special key are asynchronous pins.
  The executor of a buffered string answers exec_done when finished.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cmd_defines.svh"
// Function
// - immediate mode executes each character alone
// - immediate mode after reset
// - deferred mode buffers 82, runs on marker
// - markers are LF, bang or END
// - 82nd character acts as marker
// - @3 selects immediate, @2 deferred
// - hold handshake busy while full buffer runs
// - short unterminated string stored, bus freed
// - short learn code offers 16-byte image
// - returned short image recognised by header
// - stray byte instead of image ends short learn
// - save slot 1 on entry, restore on exit
// - short learn disables correction, sweeps, keys, requests
// - EOI with sixteenth short image byte
// - frequency and modulation readouts show dashes
// - image framing offset persists until power cycle; here it clears once the image byte count completes
// - full learn code offers 189-byte image
// - returned full image recognised by header
// - EOI with 189th full image byte
// - full image upload also stores slot 1
// - special 89 raises operator response request
module cmd_front (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire cmd_pkg::byte_t rx_data,
  input  wire logic          rx_valid,
  output var  logic          rx_ready,
  input  wire logic          atn_pin,
  input  wire logic          eoi_pin,
  output var  logic          ndac_hold,
  output var  cmd_pkg::byte_t tx_data,
  output var  logic          tx_valid,
  output var  logic          tx_eoi,
  input  wire logic          tx_take,
  input  wire cmd_pkg::byte_t image_in,
  output var  logic [7:0]    image_idx,
  output var  cmd_pkg::byte_t image_out,
  output var  logic          image_we,
  output var  logic          image_short,
  output var  logic          exec_start,
  output var  logic [6:0]    exec_len,
  input  wire logic [6:0]    exec_rd_idx,
  output var  cmd_pkg::byte_t exec_rd_data,
  input  wire logic          exec_done,
  output var  logic          save_slot,
  output var  logic          recall_slot,
  output var  logic [3:0]    slot_num,
  output var  logic          learn_lock,
  output var  logic          dashes_on,
  input  wire logic          sf89_pin,
  input  wire logic          local_mode,
  input  wire logic [7:0]    service_request_mask,
  output var  logic          op_request,
  output var  logic          srq_out,
  output var  logic          deferred_mode
);
  import cmd_pkg::*;

  logic [2:0] pins_s;
  sync2 #(.W(3)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   ({atn_pin, eoi_pin, sf89_pin}),
    .pin_sync (pins_s)
  );
  logic atn_s, eoi_s, sf89_s;
  assign atn_s  = pins_s[2];
  assign eoi_s  = pins_s[1];
  assign sf89_s = pins_s[0];

  byte_t       buf_mem [0:81];
  logic [6:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d;
  logic        defer_q, defer_d;
  byte_t       first_q, first_d;
  logic        have_first_q, have_first_d;
  learn_kind_t up_q, up_d;
  learn_kind_t down_q, down_d;
  logic [7:0]  pos_q, pos_d;
  logic        lock_q, lock_d;
  logic        hdr_q, hdr_d;
  byte_t       hdr0_q, hdr0_d;
  logic        sf89_old_q, sf89_old_d;
  logic        opreq_q, opreq_d;
  logic        start_q, start_d;
  logic        save_q, save_d, recall_q, recall_d, we_q, we_d;
  byte_t       img_q, img_d;

  logic take, is_mark, learn_byte, end_of_string_marker;
  assign take = rx_valid && rx_ready;
  assign is_mark = (rx_data == `CH_LF) || (rx_data == `CH_BANG)
                   || (eoi_s && !atn_s);
  assign learn_byte = lock_q || hdr_q || down_q != XF_NONE;

  always_comb begin
    cnt_d = cnt_q; busy_d = busy_q; defer_d = defer_q;
    first_d = first_q; have_first_d = have_first_q;
    up_d = up_q; down_d = down_q; pos_d = pos_q; lock_d = lock_q;
    hdr_d = hdr_q; hdr0_d = hdr0_q; start_d = 1'b0;
    save_d = 1'b0; recall_d = 1'b0; we_d = 1'b0; img_d = img_q;
    sf89_old_d = sf89_s;
    opreq_d = opreq_q;
    end_of_string_marker = 1'b0;
    if (sf89_s && !sf89_old_q && local_mode) opreq_d = 1'b1;
    if (busy_q && exec_done) begin
      busy_d = 1'b0;
      cnt_d  = '0;
    end
    if (up_q != XF_NONE && tx_take) begin
      if (pos_q == ((up_q == XF_SHORT) ? `SHORT_LEN : `FULL_LEN) - 8'd1) begin
        up_d = XF_NONE;
        pos_d = '0;
      end else begin
        pos_d = pos_q + 8'd1;
      end
    end
    if (take && up_q == XF_NONE) begin
      if (down_q != XF_NONE) begin
        // Positional framing: a lost byte shifts the rest of this image, which then ends on the next byte received.
        we_d = 1'b1; img_d = rx_data;
        if (pos_q == ((down_q == XF_SHORT) ? `SHORT_LEN : `FULL_LEN) - 8'd1) begin
          down_d = XF_NONE; pos_d = '0;
        end else pos_d = pos_q + 8'd1;
      end else if (hdr_q) begin
        hdr_d = 1'b0; pos_d = 8'd2;
        if (hdr0_q == `SHORT_HDR0 && rx_data == `SHORT_HDR1) down_d = XF_SHORT;
        else if (hdr0_q == `FULL_HDR0 && rx_data == `FULL_HDR1) down_d = XF_FULL;
        else begin
          pos_d = '0;
          if (hdr0_q == `CH_AT && rx_data == `CH_THREE) defer_d = 1'b0;
          else if (hdr0_q == `CH_AT && rx_data == `CH_TWO) defer_d = 1'b1;
          else if (lock_q) begin lock_d = 1'b0; recall_d = 1'b1; end
        end
      end else if (rx_data == `CH_AT || rx_data == `CH_TICK) begin
        hdr_d = 1'b1; hdr0_d = rx_data;
        have_first_d = 1'b0;
      end else if (lock_q) begin
        lock_d = 1'b0; recall_d = 1'b1;
      end else if (have_first_q) begin
        have_first_d = 1'b0;
        if (first_q == `CH_AT && rx_data == `CH_THREE) defer_d = 1'b0;
        else if (first_q == `CH_AT && rx_data == `CH_TWO) defer_d = 1'b1;
        else if (first_q == `CH_L && rx_data == `CH_TWO) begin
          up_d = XF_SHORT; pos_d = '0; lock_d = 1'b1; save_d = 1'b1;
        end else if (first_q == `CH_L && rx_data == `CH_ONE) begin
          up_d = XF_FULL; pos_d = '0; save_d = 1'b1;
        end
      end else if (!(rx_data == `CH_LF || rx_data == `CH_BANG)) begin
        first_d = rx_data; have_first_d = 1'b1;
      end
      if (!learn_byte) begin
        if (defer_q) begin
          cnt_d = cnt_q + 7'd1;
          end_of_string_marker = is_mark || (cnt_q + 7'd1 == `STR_MAX);
        end else begin
          cnt_d = 7'd1;
          end_of_string_marker = 1'b1;
        end
        if (end_of_string_marker) begin
          busy_d = 1'b1; start_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (take && !learn_byte && up_q == XF_NONE)
      buf_mem[defer_q ? cnt_q : 7'd0] <= rx_data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0; busy_q <= 1'b0; defer_q <= 1'b0;
      first_q <= '0; have_first_q <= 1'b0;
      up_q <= XF_NONE; down_q <= XF_NONE; pos_q <= '0; lock_q <= 1'b0;
      hdr_q <= 1'b0; hdr0_q <= '0; sf89_old_q <= 1'b0; opreq_q <= 1'b0;
      start_q <= 1'b0; save_q <= 1'b0; recall_q <= 1'b0; we_q <= 1'b0; img_q <= '0;
      rx_ready <= 1'b0; ndac_hold <= 1'b0; tx_data <= '0; tx_valid <= 1'b0;
      tx_eoi <= 1'b0; image_idx <= '0; image_out <= '0; image_we <= 1'b0;
      image_short <= 1'b0; exec_start <= 1'b0; exec_len <= '0; exec_rd_data <= '0;
      save_slot <= 1'b0; recall_slot <= 1'b0; slot_num <= '0; learn_lock <= 1'b0;
      dashes_on <= 1'b0; op_request <= 1'b0; srq_out <= 1'b0; deferred_mode <= 1'b0;
    end else begin
      cnt_q <= cnt_d; busy_q <= busy_d; defer_q <= defer_d;
      first_q <= first_d; have_first_q <= have_first_d;
      up_q <= up_d; down_q <= down_d; pos_q <= pos_d; lock_q <= lock_d;
      hdr_q <= hdr_d; hdr0_q <= hdr0_d; sf89_old_q <= sf89_old_d; opreq_q <= opreq_d;
      start_q <= start_d; save_q <= save_d; recall_q <= recall_d; we_q <= we_d;
      img_q <= img_d;
      rx_ready <= !busy_d && up_d == XF_NONE;
      ndac_hold <= busy_d;
      tx_valid <= up_d != XF_NONE;
      tx_data <= image_in;
      tx_eoi <= (up_d == XF_SHORT && pos_d == `SHORT_LEN - 8'd1)
                || (up_d == XF_FULL && pos_d == `FULL_LEN - 8'd1);
      image_idx <= pos_d;
      image_out <= img_d;
      image_we <= we_d;
      image_short <= (down_d == XF_SHORT) || (up_d == XF_SHORT);
      exec_start <= start_d;
      exec_len <= cnt_d;
      exec_rd_data <= buf_mem[exec_rd_idx];
      save_slot <= save_d;
      recall_slot <= recall_d;
      slot_num <= `SLOT_LEARN;
      learn_lock <= lock_d;
      dashes_on <= lock_d;
      op_request <= opreq_d;
      // Requests are held off while the short image session owns the panel.
      srq_out <= opreq_d && service_request_mask[7] && !lock_d;
      deferred_mode <= defer_d;
    end
  end
endmodule : cmd_front
`default_nettype wire

// ==== cmd_front_monitor.sv ====
/* Checker for cmd_front: timing of execution, handshake and learn outputs.
   Assumes one core_clk domain with rst as its asynchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module cmd_front_monitor (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       rx_ready,
  input wire logic       ndac_hold,
  input wire logic       tx_valid,
  input wire logic       tx_eoi,
  input wire logic       exec_start,
  input wire logic [6:0] exec_len,
  input wire logic       exec_done,
  input wire logic       save_slot,
  input wire logic       recall_slot,
  input wire logic [3:0] slot_num,
  input wire logic       learn_lock,
  input wire logic       dashes_on,
  input wire logic       op_request,
  input wire logic       srq_out,
  input wire logic       deferred_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_busy; ndac_hold && !exec_done; endsequence
  sequence s_locked; learn_lock ##1 learn_lock; endsequence
  a_hold_busy: assert property (s_busy |=> ndac_hold)
    else $error("handshake freed before execution ended");
  a_done_frees: assert property (ndac_hold && exec_done |-> ##[1:3] !ndac_hold)
    else $error("handshake still busy after execution");
  a_busy_closed: assert property (ndac_hold |-> !rx_ready)
    else $error("byte accepted while busy");
  a_len_range: assert property (exec_start |-> exec_len inside {[7'h01:7'h52]})
    else $error("string length out of range");
  a_imm_single: assert property (exec_start && !deferred_mode && !$past(deferred_mode)
    |-> exec_len == 7'h01)
    else $error("immediate mode ran more than one character");
  a_slot_one: assert property (save_slot || recall_slot |-> slot_num == 4'h1)
    else $error("learn slot is not one");
  a_eoi_valid: assert property (tx_eoi |-> tx_valid)
    else $error("end flag without a byte");
  a_dash_lock: assert property (learn_lock |-> dashes_on)
    else $error("readouts not dashed in short learn");
  a_quiet_lock: assert property (s_locked |-> !srq_out)
    else $error("service request during short learn");
  a_srq_cause: assert property (srq_out |-> op_request)
    else $error("service request without cause");
endmodule : cmd_front_monitor
bind cmd_front cmd_front_monitor u_mon (
  .core_clk(core_clk), .rst(rst), .rx_ready(rx_ready), .ndac_hold(ndac_hold),
  .tx_valid(tx_valid), .tx_eoi(tx_eoi), .exec_start(exec_start), .exec_len(exec_len),
  .exec_done(exec_done), .save_slot(save_slot), .recall_slot(recall_slot),
  .slot_num(slot_num), .learn_lock(learn_lock), .dashes_on(dashes_on),
  .op_request(op_request), .srq_out(srq_out), .deferred_mode(deferred_mode));
`default_nettype wire

// ==== bus_partner.sv ====
/* Far side of cmd_front: bus controller reading talk bytes and the string executor.
   Assumes all pulses are sampled on rising core_clk edges. */
`timescale 1ns/100ps
`default_nettype none
module bus_partner (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic tx_valid,
  output var  logic tx_take,
  input  wire logic exec_start,
  output var  logic exec_done
);
  logic [4:0] tc_q;
  logic [4:0] ec_q;
  // Spacing of at least three edges lets the one-cycle-late talk byte settle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tc_q      <= 5'h00;
      ec_q      <= 5'h00;
      tx_take   <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      tx_take   <= tx_valid && !tx_take && tc_q >= (slow ? 5'h09 : 5'h02);
      tc_q      <= (tx_valid && !tx_take) ? tc_q + 5'h01 : 5'h00;
      exec_done <= (ec_q == 5'h01);
      ec_q      <= exec_start ? (slow ? 5'h14 : 5'h03) : (ec_q != 5'h00 ? ec_q - 5'h01 : 5'h00);
    end
  end
endmodule : bus_partner
`default_nettype wire

// ==== gpib_exec_mode_and_learn_tb.sv ====
/* Self-checking bench for cmd_front: modes, string buffering and both learn images.
   Assumes bus_partner and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module gpib_exec_mode_and_learn_tb;
  import cmd_pkg::*;
  logic        core_clk, rst, rx_valid, atn_pin, eoi_pin, sf89_pin, local_mode, slow, ign, rd_chk;
  byte_t       rx_data, fc, srq_mask;
  byte_t       panel [0:255];
  logic [31:0] lfsr;
  logic [14:0] qe [$];
  logic [8:0]  qt [$];
  logic [8:0]  rd_exp;
  int          fails, total_checks, saves, recalls, writes;
  wire logic   image_we;
  wire byte_t  tx_data, image_in, exec_rd_data;
  wire logic [7:0] image_idx;
  wire logic [6:0] exec_len;
  wire logic   rx_ready, ndac_hold, tx_valid, tx_eoi, tx_take, exec_start, exec_done, save_slot;
  wire logic   recall_slot, learn_lock, dashes_on, op_request, srq_out, deferred_mode;
  // The panel image is a memory read, so it follows the index without a register.
  assign image_in = panel[image_idx];
  cmd_front dut (.core_clk(core_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .atn_pin(atn_pin), .eoi_pin(eoi_pin), .ndac_hold(ndac_hold),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_eoi(tx_eoi), .tx_take(tx_take),
    .image_in(image_in), .image_idx(image_idx), .image_out(), .image_we(image_we),
    .image_short(),
    .exec_start(exec_start), .exec_len(exec_len), .exec_rd_idx(7'h00),
    .exec_rd_data(exec_rd_data), .exec_done(exec_done), .save_slot(save_slot),
    .recall_slot(recall_slot), .slot_num(), .learn_lock(learn_lock), .dashes_on(dashes_on),
    .sf89_pin(sf89_pin), .local_mode(local_mode), .service_request_mask(srq_mask),
    .op_request(op_request), .srq_out(srq_out), .deferred_mode(deferred_mode));
  bus_partner u_far (.core_clk(core_clk), .rst(rst), .slow(slow), .tx_valid(tx_valid),
    .tx_take(tx_take), .exec_start(exec_start), .exec_done(exec_done));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic check(input string nm, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic send(input byte_t b);
    int n;
    rx_data  <= b;
    rx_valid <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (rx_ready !== 1'b1 && n < 3000);
    rx_valid <= 1'b0;
    @(posedge core_clk);
  endtask : send
  task automatic idle();
    int n;
    n = 0;
    while ((qt.size() != 0 || ndac_hold !== 1'b0 || rx_ready !== 1'b1) && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (6) @(posedge core_clk);
  endtask : idle
  task automatic raw(input byte_t b);
    ign = 1'b1;
    send(b);
    idle();
    ign = 1'b0;
  endtask : raw
  // Letters A to K only, so no stray command code or marker is formed.
  task automatic blk(input int n, input int cs, input int mark);
    byte_t c;
    for (int i = 0; i < n; i++) begin
      lfsr = nxt(lfsr);
      c = 8'h41 + byte_t'(lfsr[7:0] % 8'h0B);
      if (i % cs == 0) fc = c;
      if (i % cs == 0 && (n - i >= cs || mark != 0))
        qe.push_back({7'(n - i >= cs ? cs : n - i + (mark == 1 || mark == 2)), c});
      if (i == n - 1 && mark == 3) begin
        eoi_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
      end
      send(c);
    end
    eoi_pin <= 1'b0;
    if (mark == 1) send(8'h0A);
    if (mark == 2) send(8'h21);
    idle();
  endtask : blk
  task automatic learn(input int len, input byte_t h0, input byte_t h1);
    int s;
    int w;
    s = saves;
    w = writes;
    panel[0] = h0;
    panel[1] = h1;
    raw(8'h4C);
    for (int i = 0; i < len; i++) qt.push_back({i == len - 1, panel[i]});
    raw(len == 16 ? 8'h32 : 8'h31);
    check("save", 9'h001, 9'(saves - s));
    ign = 1'b1;
    for (int i = 0; i < len; i++) send(panel[i]);
    idle();
    ign = 1'b0;
    check("writes", 9'(len - 2), 9'(writes - w));
  endtask : learn
  always @(posedge core_clk) begin
    if (rd_chk) check("first", rd_exp, {1'b0, exec_rd_data});
    rd_chk = 1'b0;
    if (exec_start === 1'b1) begin
      if (qe.size() != 0) begin
        check("len", {2'b00, qe[0][14:8]}, {2'b00, exec_len});
        rd_exp = {1'b0, qe[0][7:0]};
        rd_chk = 1'b1;
        void'(qe.pop_front());
      end else if (!ign) check("exec", 9'h000, 9'h001);
    end
    if (tx_valid === 1'b1 && tx_take === 1'b1) check("tx", qt.pop_front(), {tx_eoi, tx_data});
    saves += (save_slot === 1'b1);
    recalls += (recall_slot === 1'b1);
    writes += (image_we === 1'b1);
  end
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    final_report();
  end
  initial begin
    lfsr = 32'hA8DD38A8;
    {rst, rx_valid, atn_pin, eoi_pin, sf89_pin, local_mode, slow, ign, rd_chk} = 9'h100;
    writes = 0;
    rx_data = 8'h00;
    srq_mask = 8'h00;
    for (int i = 0; i < 256; i++) begin
      lfsr = nxt(lfsr);
      panel[i] = lfsr[7:0];
    end
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("mode", 9'h000, {8'h00, deferred_mode});
    blk(6, 1, 0);
    raw(8'h40);
    raw(8'h32);
    check("mode", 9'h001, {8'h00, deferred_mode});
    blk(4, 82, 1);
    blk(3, 82, 2);
    slow <= 1'b1;
    blk(100, 82, 3);
    slow <= 1'b0;
    blk(5, 82, 0);
    check("free", 9'h001, {8'h00, rx_ready});
    qe.push_back({7'h06, fc});
    send(8'h0A);
    idle();
    raw(8'h40);
    raw(8'h33);
    check("mode", 9'h000, {8'h00, deferred_mode});
    learn(16, 8'h40, 8'h82);
    check("lock", 9'h003, {7'h00, learn_lock, dashes_on});
    raw(8'h55);
    check("lock", 9'h000, {7'h00, learn_lock, dashes_on});
    check("recall", 9'h001, 9'(recalls));
    learn(189, 8'hC0, 8'h31);
    local_mode <= 1'b1;
    sf89_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    sf89_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("request", 9'h002, {7'h00, op_request, srq_out});
    srq_mask <= 8'h80;
    repeat (4) @(posedge core_clk);
    check("request", 9'h003, {7'h00, op_request, srq_out});
    check("pending", 9'h000, 9'(qe.size()));
    final_report();
  end
endmodule : gpib_exec_mode_and_learn_tb
`default_nettype wire
